// ---- hdl/config_access_router_defs.svh ----
// Offsets, field positions, reset values and codes of the configuration access router.
`ifndef CONFIG_ACCESS_ROUTER_DEFS_SVH
`define CONFIG_ACCESS_ROUTER_DEFS_SVH

`define CFG_POINTER_ADDR 16'h0CF8
`define CFG_DATA_ADDR 16'h0CFC
`define CFG_POINTER_RESET 32'h0000_0000
`define IO_ADDR_WIDTH 16
`define FULL_DWORD_BE 4'hF

`define PTR_ENABLE_BIT 31
`define PTR_BUS_HI 23
`define PTR_BUS_LO 16
`define PTR_DEV_HI 15
`define PTR_DEV_LO 11
`define PTR_FUNC_HI 10
`define PTR_FUNC_LO 8
`define PTR_REG_HI 7
`define PTR_REG_LO 2

`define ROOT_BUS 8'h00
`define PRIMARY_BUS_RESET 8'h00
`define DEV_HOST_BRIDGE 5'h00
`define DEV_GFX_BRIDGE 5'h01
`define DEV_NET_BRIDGE 5'h03
`define DEV_OVERFLOW 5'h06
`define FUNC_OVERFLOW 3'h0

`define CYCLE_TYPE0_CODE 2'h0
`define CYCLE_TYPE1_CODE 2'h1

`endif

// ---- hdl/config_access_router_pkg.sv ----
// Types shared by the configuration access router files.
package config_access_router_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } state_e;

    typedef enum logic [3:0] {
        RT_LOCAL = 4'b0001,
        RT_INT = 4'b0010,
        RT_HUB = 4'b0100,
        RT_GFX = 4'b1000
    } route_e;

    typedef enum logic [1:0] {
        FN_HOST = 2'h0,
        FN_GFX = 2'h1,
        FN_NET = 2'h2,
        FN_OVERFLOW = 2'h3
    } int_fn_e;

endpackage : config_access_router_pkg

// ---- hdl/cfg_idsel_decode.sv ----
// One-hot device select for type 0 cycles on the graphics port.
`timescale 1ns/1ps
module cfg_idsel_decode #(
    parameter int SEL_WIDTH = 16
) (
    input wire logic [4:0] devNum,
    output logic [SEL_WIDTH-1:0] idsel
);

    // Device numbers with the top bit set fall outside the select lines and drive none.
    genvar i;
    generate
        for (i = 0; i < SEL_WIDTH; i = i + 1) begin : g_sel
            assign idsel[i] = (devNum == 5'(i));
        end
    endgenerate

endmodule : cfg_idsel_decode

// ---- hdl/config_access_router.sv ----
// Configuration access router: decodes processor I/O cycles and routes configuration cycles.
//
// Function
// - Pointer register decoded at I/O 0CF8h, doubleword.
// - Data window decoded at I/O 0CFCh; byte enables select 0CFCh to 0CFFh.
// - Configuration cycles only while pointer bit 31 set.
// - Window gives byte-granular access to selected doubleword.
// - Each window access with bit 31 set becomes a configuration cycle.
// - Bus number from bits 23:16; device decoded.
// - Bus number zero targets bus 0 devices.
// - Bus 0 device 0 selects host bridge.
// - Bus 0 device 1 selects graphics bridge.
// - Bus 0 device 3 selects network bridge.
// - Bus 0 device 6 function 0 selects overflow.
// - Hub devices and expansion buses use hub link.
// - Graphics routing uses bridge bus number range.
// - Bus outside graphics range: hub-link type 1 request.
// - Hub-link type 1 address bits 1:0 are 01.
// - Pointer bits 31:2 copied into hub request address.
// - Eight functions, 256 byte registers each.
// - Partial pointer access forwarded as hub I/O cycle.
// - Secondary bus match: graphics type 0, one-hot select.
// - Bus within secondary and subordinate: graphics type 1.
// - Graphics bridge primary bus number fixed zero.
`timescale 1ns/1ps
`include "config_access_router_defs.svh"
module config_access_router (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ioReq,
    input wire logic ioWrite,
    input wire logic [15:0] ioAddr,
    input wire logic [3:0] ioByteEn,
    input wire logic [31:0] ioWrData,
    output logic ioDone,
    output logic [31:0] ioRdData,
    output logic intReq,
    output logic intWrite,
    output logic [1:0] intFunction,
    output logic [2:0] intFuncNum,
    output logic [5:0] intRegNum,
    output logic [3:0] intByteEn,
    output logic [31:0] intWrData,
    input wire logic intAck,
    input wire logic [31:0] intRdData,
    output logic hubReq,
    output logic hubConfig,
    output logic hubWrite,
    output logic [31:0] hubAddr,
    output logic [3:0] hubByteEn,
    output logic [31:0] hubWrData,
    input wire logic hubAck,
    input wire logic [31:0] hubRdData,
    output logic gfxReq,
    output logic gfxType1,
    output logic gfxWrite,
    output logic [31:0] gfxAddr,
    output logic [3:0] gfxByteEn,
    output logic [31:0] gfxWrData,
    input wire logic gfxAck,
    input wire logic [31:0] gfxRdData,
    input wire logic [7:0] secondaryBus,
    input wire logic [7:0] subordinateBus,
    output logic [7:0] primaryBus,
    output logic cfgEnabled
);

    config_access_router_pkg::state_e state;
    config_access_router_pkg::route_e route;
    config_access_router_pkg::route_e next_route;
    config_access_router_pkg::int_fn_e next_intFunction;
    logic [31:0] cfgPointer;
    logic [31:0] next_addr;
    logic next_config;
    logic next_type1;
    logic ptrHit;
    logic dataHit;
    logic fullDword;
    logic [7:0] busNum;
    logic [4:0] devNum;
    logic [2:0] fnNum;
    logic [15:0] idsel;
    logic accept;
    logic targetAck;

    assign accept = ioReq && (state == config_access_router_pkg::ST_IDLE);

    // Field extraction; the function and register fields address 8 x 64 doublewords.
    assign busNum = cfgPointer[`PTR_BUS_HI:`PTR_BUS_LO];
    assign devNum = cfgPointer[`PTR_DEV_HI:`PTR_DEV_LO];
    assign fnNum = cfgPointer[`PTR_FUNC_HI:`PTR_FUNC_LO];

    cfg_idsel_decode #(
        .SEL_WIDTH(16)
    ) u_idsel (
        .devNum(devNum),
        .idsel(idsel)
    );

    always_comb begin
        ptrHit = (ioAddr == `CFG_POINTER_ADDR);
        dataHit = (ioAddr == `CFG_DATA_ADDR);
        fullDword = (ioByteEn == `FULL_DWORD_BE);
        next_route = config_access_router_pkg::RT_HUB;
        next_intFunction = config_access_router_pkg::FN_HOST;
        next_config = 1'b0;
        next_type1 = 1'b0;
        next_addr = {16'h0000, ioAddr};
        if (ptrHit && fullDword) begin
            next_route = config_access_router_pkg::RT_LOCAL;
        end else if (dataHit && cfgPointer[`PTR_ENABLE_BIT]) begin
            // Window accesses become configuration cycles only here.
            next_config = 1'b1;
            if (busNum == `ROOT_BUS) begin
                // Bus 0: internal functions first, the rest belongs to the hub.
                next_route = config_access_router_pkg::RT_INT;
                next_addr = {cfgPointer[31:2], `CYCLE_TYPE0_CODE};
                case (devNum)
                    `DEV_HOST_BRIDGE: begin
                        next_intFunction = config_access_router_pkg::FN_HOST;
                    end
                    `DEV_GFX_BRIDGE: begin
                        next_intFunction = config_access_router_pkg::FN_GFX;
                    end
                    `DEV_NET_BRIDGE: begin
                        next_intFunction = config_access_router_pkg::FN_NET;
                    end
                    `DEV_OVERFLOW: begin
                        if (fnNum == `FUNC_OVERFLOW) begin
                            next_intFunction = config_access_router_pkg::FN_OVERFLOW;
                        end else begin
                            next_route = config_access_router_pkg::RT_HUB;
                        end
                    end
                    default: begin
                        next_route = config_access_router_pkg::RT_HUB;
                    end
                endcase
            end else if (busNum == secondaryBus) begin
                // Type 0 on the graphics port: select lines above, function and register below.
                next_route = config_access_router_pkg::RT_GFX;
                next_addr = {idsel, 5'h00, cfgPointer[10:2], `CYCLE_TYPE0_CODE};
            end else if ((busNum > secondaryBus) && (busNum <= subordinateBus)) begin
                next_route = config_access_router_pkg::RT_GFX;
                next_type1 = 1'b1;
                next_addr = {8'h00, cfgPointer[23:2], `CYCLE_TYPE1_CODE};
            end else begin
                // Below secondary or above subordinate: the hub resolves the rest.
                next_route = config_access_router_pkg::RT_HUB;
                next_type1 = 1'b1;
                next_addr = {cfgPointer[31:2], `CYCLE_TYPE1_CODE};
            end
        end
        // Anything else, including byte or word pointer accesses and window accesses
        // with the enable clear, falls through as a plain hub I/O cycle.
    end

    always_comb begin
        case (route)
            config_access_router_pkg::RT_INT: targetAck = intAck;
            config_access_router_pkg::RT_HUB: targetAck = hubAck;
            config_access_router_pkg::RT_GFX: targetAck = gfxAck;
            default: targetAck = 1'b0;
        endcase
    end

    // Pointer register; only a full doubleword write to its address loads it.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfgPointer <= `CFG_POINTER_RESET;
        end else if (accept && ioWrite && (next_route == config_access_router_pkg::RT_LOCAL)) begin
            cfgPointer <= ioWrData;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfgEnabled <= 1'b0;
        end else begin
            cfgEnabled <= cfgPointer[`PTR_ENABLE_BIT];
        end
    end

    // The primary bus of the graphics bridge is bus 0 and has no write path.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            primaryBus <= `PRIMARY_BUS_RESET;
        end else begin
            primaryBus <= `PRIMARY_BUS_RESET;
        end
    end

    // Transaction sequencing: one cycle outstanding at a time.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= config_access_router_pkg::ST_IDLE;
            route <= config_access_router_pkg::RT_LOCAL;
        end else begin
            case (state)
                config_access_router_pkg::ST_IDLE: begin
                    if (accept) begin
                        route <= next_route;
                        if (next_route != config_access_router_pkg::RT_LOCAL) begin
                            state <= config_access_router_pkg::ST_WAIT;
                        end
                    end
                end
                config_access_router_pkg::ST_WAIT: begin
                    if (targetAck) begin
                        state <= config_access_router_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= config_access_router_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Internal configuration functions. Byte enables pass unchanged.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            intReq <= 1'b0;
            intWrite <= 1'b0;
            intFunction <= 2'h0;
            intFuncNum <= 3'h0;
            intRegNum <= 6'h00;
            intByteEn <= 4'h0;
            intWrData <= 32'h0000_0000;
        end else if (accept && (next_route == config_access_router_pkg::RT_INT)) begin
            intReq <= 1'b1;
            intWrite <= ioWrite;
            intFunction <= next_intFunction;
            intFuncNum <= fnNum;
            intRegNum <= cfgPointer[`PTR_REG_HI:`PTR_REG_LO];
            intByteEn <= ioByteEn;
            intWrData <= ioWrData;
        end else if (intAck) begin
            intReq <= 1'b0;
        end
    end

    // Hub link: configuration requests and forwarded I/O cycles.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hubReq <= 1'b0;
            hubConfig <= 1'b0;
            hubWrite <= 1'b0;
            hubAddr <= 32'h0000_0000;
            hubByteEn <= 4'h0;
            hubWrData <= 32'h0000_0000;
        end else if (accept && (next_route == config_access_router_pkg::RT_HUB)) begin
            hubReq <= 1'b1;
            hubConfig <= next_config;
            hubWrite <= ioWrite;
            hubAddr <= next_addr;
            hubByteEn <= ioByteEn;
            hubWrData <= ioWrData;
        end else if (hubAck) begin
            hubReq <= 1'b0;
        end
    end

    // Graphics port configuration cycles.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gfxReq <= 1'b0;
            gfxType1 <= 1'b0;
            gfxWrite <= 1'b0;
            gfxAddr <= 32'h0000_0000;
            gfxByteEn <= 4'h0;
            gfxWrData <= 32'h0000_0000;
        end else if (accept && (next_route == config_access_router_pkg::RT_GFX)) begin
            gfxReq <= 1'b1;
            gfxType1 <= next_type1;
            gfxWrite <= ioWrite;
            gfxAddr <= next_addr;
            gfxByteEn <= ioByteEn;
            gfxWrData <= ioWrData;
        end else if (gfxAck) begin
            gfxReq <= 1'b0;
        end
    end

    // Processor answer. A pointer access completes one edge after it is taken;
    // routed cycles complete one edge after the target acknowledges.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ioDone <= 1'b0;
            ioRdData <= 32'h0000_0000;
        end else begin
            ioDone <= 1'b0;
            if (accept && (next_route == config_access_router_pkg::RT_LOCAL)) begin
                ioDone <= 1'b1;
                if (!ioWrite) begin
                    ioRdData <= cfgPointer;
                end
            end else if ((state == config_access_router_pkg::ST_WAIT) && targetAck) begin
                ioDone <= 1'b1;
                // The held request's write flag decides, since the processor inputs may have moved on.
                case (route)
                    config_access_router_pkg::RT_INT: ioRdData <= intWrite ? ioRdData : intRdData;
                    config_access_router_pkg::RT_HUB: ioRdData <= hubWrite ? ioRdData : hubRdData;
                    config_access_router_pkg::RT_GFX: ioRdData <= gfxWrite ? ioRdData : gfxRdData;
                    default: ioRdData <= ioRdData;
                endcase
            end
        end
    end

endmodule : config_access_router

// ---- sim/ack_responder.sv ----
// Behavioural target that answers a routed request after a chosen number of cycles.
`timescale 1ns/1ps
module ack_responder (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req,
    input wire logic [1:0] delay,
    input wire logic [31:0] rdValue,
    output logic ack,
    output logic [31:0] rdData
);
    logic [1:0] waited;
    logic [7:0] stamp;
    // Outside the answer cycle the data shows a changing wrong value, so a late or early sample is caught.
    assign rdData = ack ? rdValue : ~rdValue ^ {24'h000000, stamp};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack <= 1'b0;
            waited <= 2'h0;
        end else if (req && !ack && waited == delay) begin
            ack <= 1'b1;
            waited <= 2'h0;
        end else begin
            ack <= 1'b0;
            waited <= (req && !ack) ? waited + 2'h1 : 2'h0;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stamp <= 8'h00;
        end else begin
            stamp <= stamp + 8'h01;
        end
    end
endmodule : ack_responder

// ---- sim/router_checker_assertions.sv ----
// Assertion checker watching the configuration access router ports.
`timescale 1ns/1ps
`include "config_access_router_defs.svh"
module router_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ioReq,
    input wire logic ioWrite,
    input wire logic [15:0] ioAddr,
    input wire logic [3:0] ioByteEn,
    input wire logic [31:0] ioWrData,
    input wire logic ioDone,
    input wire logic intReq,
    input wire logic intAck,
    input wire logic hubReq,
    input wire logic hubConfig,
    input wire logic [31:0] hubAddr,
    input wire logic hubAck,
    input wire logic gfxReq,
    input wire logic gfxType1,
    input wire logic [31:0] gfxAddr,
    input wire logic gfxAck,
    input wire logic [7:0] primaryBus,
    input wire logic cfgEnabled
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic pending;
    logic ptrEn;
    logic taken;
    logic isPtr;
    logic acked;
    logic anyReq;
    assign taken = ioReq && !pending;
    assign isPtr = ioAddr == `CFG_POINTER_ADDR && ioByteEn == `FULL_DWORD_BE;
    assign acked = (intReq && intAck) || (hubReq && hubAck) || (gfxReq && gfxAck);
    assign anyReq = intReq || hubReq || gfxReq;
    // Mirrors the busy span, so a request ignored while busy never arms a check.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) pending <= 1'b0;
        else if (taken && !isPtr) pending <= 1'b1;
        else if (acked) pending <= 1'b0;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) ptrEn <= 1'b0;
        else if (taken && isPtr && ioWrite) ptrEn <= ioWrData[31];
    end
    sequence ptrAccess; taken && isPtr; endsequence
    sequence ptrWrite; taken && isPtr && ioWrite; endsequence
    sequence routed; taken && !isPtr; endsequence
    sequence winOff; taken && !isPtr && ioAddr == `CFG_DATA_ADDR && !ptrEn; endsequence
    chk_ptr_answer: assert property (ptrAccess |=> ioDone && !anyReq)
        else $error("pointer access not answered next cycle");
    chk_enable_follow: assert property (ptrWrite |-> ##2 cfgEnabled == $past(ioWrData[31], 2))
        else $error("enable flag does not follow pointer bit");
    chk_route_start: assert property (routed |=> $onehot({intReq, hubReq, gfxReq}))
        else $error("routed access raised no single request");
    chk_single_target: assert property ($onehot0({intReq, hubReq, gfxReq}))
        else $error("more than one target requested");
    chk_ack_finish: assert property (acked |=> ioDone && !anyReq)
        else $error("acknowledge not followed by answer");
    chk_window_gate: assert property (winOff |=> hubReq && !hubConfig)
        else $error("window access with enable clear not plain I/O");
    chk_hub_hold: assert property (hubReq && !hubAck |=> hubReq && $stable(hubAddr))
        else $error("hub request dropped or changed early");
    chk_hub_type1: assert property (hubReq && hubConfig && hubAddr[23:16] != 8'h00 |-> hubAddr[1:0] == 2'h1)
        else $error("hub type 1 code wrong");
    chk_gfx_select: assert property (gfxReq && !gfxType1 |-> $onehot0(gfxAddr[31:16]) && gfxAddr[1:0] == 2'h0)
        else $error("graphics type 0 select not one-hot");
    chk_gfx_type1: assert property (gfxReq && gfxType1 |-> gfxAddr[1:0] == 2'h1)
        else $error("graphics type 1 code wrong");
    chk_primary_zero: assert property (primaryBus == 8'h00)
        else $error("primary bus number not zero");
endmodule : router_checker
bind config_access_router router_checker checker_i (.clk, .reset_n, .ioReq, .ioWrite, .ioAddr, .ioByteEn,
    .ioWrData, .ioDone, .intReq, .intAck, .hubReq, .hubConfig, .hubAddr, .hubAck, .gfxReq, .gfxType1, .gfxAddr,
    .gfxAck, .primaryBus, .cfgEnabled);

// ---- sim/tb_top.sv ----
// Self-checking testbench for the configuration access router.
`timescale 1ns/1ps
`include "config_access_router_defs.svh"
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin mismatches++; \
    $display("[ERR] %0t mismatch %h vs %h", $time, (a), (b)); end end
module tb_top;
    logic clk, reset_n, ioReq, ioWrite, ioDone, intReq, intWrite, intAck, hubReq, hubConfig, hubWrite, hubAck;
    logic gfxReq, gfxType1, gfxWrite, gfxAck, cfgEnabled;
    logic [15:0] ioAddr;
    logic [3:0] ioByteEn, intByteEn, hubByteEn, gfxByteEn;
    logic [31:0] ioWrData, ioRdData, intWrData, intRdData, hubAddr, hubWrData, hubRdData;
    logic [31:0] gfxAddr, gfxWrData, gfxRdData, ptr, rdv, seed;
    logic [1:0] intFunction, dly;
    logic [2:0] intFuncNum;
    logic [5:0] intRegNum;
    logic [7:0] secondaryBus, subordinateBus, primaryBus;
    int mismatches = 0;
    int nTests = 0;
    int p;
    logic [31:0] tbl [14] = '{32'h8000_0004, 32'h8000_0810, 32'h8000_1A3C, 32'h8000_30FC,
        32'h8000_3104, 32'h8000_1000, 32'h8005_1008, 32'h8005_8000, 32'h8005_7F40,
        32'h8006_0844, 32'h8009_FFFC, 32'h800A_0000, 32'h8003_0004, 32'h0000_0004};
    initial clk = 1'b0;
    always #10 clk = ~clk;
    config_access_router DUT (.clk, .reset_n, .ioReq, .ioWrite, .ioAddr, .ioByteEn, .ioWrData, .ioDone, .ioRdData,
        .intReq, .intWrite, .intFunction, .intFuncNum, .intRegNum, .intByteEn, .intWrData, .intAck, .intRdData,
        .hubReq, .hubConfig, .hubWrite, .hubAddr, .hubByteEn, .hubWrData, .hubAck, .hubRdData, .gfxReq, .gfxType1,
        .gfxWrite, .gfxAddr, .gfxByteEn, .gfxWrData, .gfxAck, .gfxRdData, .secondaryBus, .subordinateBus,
        .primaryBus, .cfgEnabled);
    ack_responder intSide (.clk, .reset_n, .req(intReq), .delay(dly), .rdValue(rdv), .ack(intAck),
        .rdData(intRdData));
    ack_responder hubSide (.clk, .reset_n, .req(hubReq), .delay(dly), .rdValue(~rdv), .ack(hubAck),
        .rdData(hubRdData));
    ack_responder gfxSide (.clk, .reset_n, .req(gfxReq), .delay(dly), .rdValue({rdv[15:0], rdv[31:16]}),
        .ack(gfxAck), .rdData(gfxRdData));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic wrapUp();
        if (mismatches == 0 && nTests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrapUp
    // Model of the routing decision; called at a falling edge, returns at the falling edge of the answer.
    task automatic io(input logic wr, input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
        int route, got, i;
        logic [31:0] ea, ga;
        logic [36:0] gv;
        logic [10:0] gi;
        logic [1:0] efn;
        logic ecfg, t1, gc, gt;
        logic [4:0] dev;
        logic [7:0] bus;
        bus = ptr[23:16];
        dev = ptr[15:11];
        {route, ecfg, t1, efn, got} = {32'd2, 1'b1, 1'b0, 2'h0, 32'd0};
        if (a == `CFG_POINTER_ADDR && be == `FULL_DWORD_BE) route = 0;
        else if (a != `CFG_DATA_ADDR || !ptr[31]) {ecfg, ea} = {1'b0, 16'h0000, a};
        else if (bus == 8'h00) begin
            route = 1;
            ea = {ptr[31:2], 2'h0};
            if (dev == 5'h00) efn = 2'h0;
            else if (dev == 5'h01) efn = 2'h1;
            else if (dev == 5'h03) efn = 2'h2;
            else if (dev == 5'h06 && ptr[10:8] == 3'h0) efn = 2'h3;
            else route = 2;
        end else if (bus == secondaryBus) begin
            route = 3;
            ea = {(dev[4] ? 16'h0000 : 16'h0001 << dev[3:0]), 5'h00, ptr[10:2], 2'h0};
        end else if (bus > secondaryBus && bus <= subordinateBus) begin
            {route, t1, ea} = {32'd3, 1'b1, 8'h00, ptr[23:2], 2'h1};
        end else ea = {ptr[31:2], 2'h1};
        dly = 2'(rnd());
        rdv = rnd();
        {ioReq, ioWrite, ioAddr, ioByteEn, ioWrData} = {1'b1, wr, a, be, d};
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            if (got == 0 && (intReq || hubReq || gfxReq)) begin
                got = intReq ? 1 : hubReq ? 2 : 3;
                {gc, gt, gi, ga} = {hubConfig, gfxType1, intFunction, intFuncNum, intRegNum, hubReq ? hubAddr : gfxAddr};
                gv = intReq ? {intWrite, intByteEn, intWrData} : hubReq ? {hubWrite, hubByteEn, hubWrData}
                    : {gfxWrite, gfxByteEn, gfxWrData};
            end
            if (ioDone) break;
        end
        if (i == 40) begin
            mismatches++;
            $display("[ERR] %0t no answer", $time);
            wrapUp();
        end
        `CHK(got, route)
        if (route == 0 && !wr) `CHK(ioRdData, ptr)
        if (route == 0 && wr) ptr = d;
        if (route == 1) `CHK(gi, {efn, ptr[10:2]})
        if (route > 1) `CHK(ga, ea)
        if (route == 2) `CHK(gc, ecfg)
        if (route == 3) `CHK(gt, t1)
        if (route > 0) `CHK(gv[36:32], {wr, be})
        if (route > 0 && wr) `CHK(gv[31:0], d)
        if (route > 0 && !wr) `CHK(ioRdData, route == 1 ? rdv : route == 2 ? ~rdv : {rdv[15:0], rdv[31:16]})
    endtask : io
    initial begin
        {reset_n, ioReq, ioWrite, ioAddr, ioByteEn, ioWrData, dly, rdv, ptr} = '0;
        {secondaryBus, subordinateBus, seed} = {8'h05, 8'h09, 32'h0000_0058};
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        `CHK(primaryBus, 8'h00)
        `CHK(cfgEnabled, 1'b0)
        io(1'b0, `CFG_POINTER_ADDR, 4'hF, 32'h0000_0000);
        for (p = 0; p < 2; p++) begin
            secondaryBus = p ? 8'h03 : 8'h05;
            subordinateBus = p ? 8'h03 : 8'h09;
            foreach (tbl[k]) begin
                io(1'b1, `CFG_POINTER_ADDR, 4'hF, tbl[k]);
                io(1'b0, `CFG_DATA_ADDR, 4'(rnd()) | 4'h1, 32'h0000_0000);
                io(1'b1, `CFG_DATA_ADDR, 4'(rnd()) | 4'h8, rnd());
            end
        end
        io(1'b1, `CFG_POINTER_ADDR, 4'hF, 32'h8000_0004);
        ioReq = 1'b0;
        @(negedge clk);
        `CHK(cfgEnabled, 1'b1)
        reset_n = 1'b0;
        @(negedge clk);
        {reset_n, ptr} = {1'b1, 32'h0000_0000};
        `CHK(cfgEnabled, 1'b0)
        io(1'b1, `CFG_POINTER_ADDR, 4'h3, 32'hFFFF_FFFF);
        io(1'b0, `CFG_POINTER_ADDR, 4'hF, 32'h0000_0000);
        io(1'b1, 16'h0080, 4'hF, rnd());
        wrapUp();
    end
endmodule : tb_top
